// ### bench/ext_osc_ctrl_properties.sv
module ext_osc_ctrl_properties (
	input wire aclk,
	input wire aresetn,
	input wire s_axi_awvalid,
	input wire s_axi_awready,
	input wire s_axi_wvalid,
	input wire s_axi_wready,
	input wire s_axi_bvalid,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire s_axi_rvalid,
	input wire [31:0] s_axi_rdata,
	input wire osc_enable,
	input wire [2:0] ext_osc_mode_sel,
	input wire resonator_in_pin_claim,
	input wire resonator_out_pin_claim,
	input wire ext_osc_clk,
	input wire periph_clk_div8
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence rd_taken;
		s_axi_arvalid && s_axi_arready;
	endsequence
	off_mode_a: assert property (osc_enable == (ext_osc_mode_sel[2:1] != 2'h0))
		else $error("enable wrong");
	xtal_pins_a: assert property (resonator_in_pin_claim == (ext_osc_mode_sel[2:1] == 2'h3))
		else $error("in pin wrong");
	one_pin_a: assert property (resonator_out_pin_claim == osc_enable)
		else $error("out pin wrong");
	off_static_a: assert property (!osc_enable [*3] |-> !ext_osc_clk && !periph_clk_div8)
		else $error("clock moves when off");
	div8_width_a: assert property ($rose(periph_clk_div8) |=> (periph_clk_div8 || !osc_enable) [*6])
		else $error("div8 too short");
	valid_zero_a: assert property (s_axi_rvalid && ext_osc_mode_sel[2:1] != 2'h3 |-> !s_axi_rdata[7])
		else $error("valid set");
	write_answer_a: assert property (wr_taken |=> !s_axi_awready ##[0:1] s_axi_bvalid)
		else $error("no write answer");
	read_answer_a: assert property (rd_taken |=> s_axi_rvalid && !s_axi_arready)
		else $error("no read answer");
endmodule // ext_osc_ctrl_properties

// ### bench/external_oscillator_control_bench.sv
`include "ext_osc_defs.vh"
bind ext_osc_ctrl ext_osc_ctrl_properties ext_osc_ctrl_properties_inst (.aclk(aclk),
	.aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rdata(s_axi_rdata), .osc_enable(osc_enable), .ext_osc_mode_sel(ext_osc_mode_sel),
	.resonator_in_pin_claim(resonator_in_pin_claim),
	.resonator_out_pin_claim(resonator_out_pin_claim), .ext_osc_clk(ext_osc_clk),
	.periph_clk_div8(periph_clk_div8));
module external_oscillator_control_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic aclk = 1'h0, aresetn = 1'h0, stall = 1'h1, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
	logic s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
	logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0, ext_osc_mode_sel, drive_range_sel;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rdat;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic [1:0] s_axi_bresp, s_axi_rresp, brsp, rrsp;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, osc_in, irq;
	logic osc_enable, resonator_in_pin_claim, resonator_out_pin_claim, ext_osc_clk, periph_clk_div8;
	int mismatches = 0, total_checks = 0, seed = 32'h1ea395d7, n, p, cm, h;
	always #2.5 aclk = !aclk;
	ext_osc_ctrl #(.GAP_CYCLES(16'h32), .SETTLE_EDGES(16'h4)) ext_osc_ctrl_inst (.aclk(aclk),
		.aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(s_axi_awprot),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arprot(s_axi_arprot),
		.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .osc_in(osc_in), .osc_enable(osc_enable),
		.ext_osc_mode_sel(ext_osc_mode_sel), .drive_range_sel(drive_range_sel),
		.resonator_in_pin_claim(resonator_in_pin_claim),
		.resonator_out_pin_claim(resonator_out_pin_claim), .ext_osc_clk(ext_osc_clk),
		.periph_clk_div8(periph_clk_div8), .irq(irq));
	osc_source osc_source_inst (.aclk(aclk), .run(osc_enable && !stall), .osc_in(osc_in));
	task stop_test;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value at %0t: %h expected %h", $time, seen, exp);
		end
	endtask
	task guard;
		if (n >= 999) begin
			mismatches++;
			stop_test;
		end
	endtask
	task wr(input logic [11:0] a, input logic [7:0] d);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		n = 0;
		do begin
			@(posedge aclk);
			n++;
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
		end while (!s_axi_bvalid && n < 999);
		s_axi_bready <= 1'h0;
		brsp = s_axi_bresp;
		guard;
	endtask
	task rd(input logic [11:0] a);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		n = 0;
		do begin
			@(posedge aclk);
			n++;
			if (s_axi_arready) s_axi_arvalid <= 1'h0;
		end while (!s_axi_rvalid && n < 999);
		s_axi_rready <= 1'h0;
		rdat = s_axi_rdata;
		rrsp = s_axi_rresp;
		guard;
	endtask
	task lvl(input logic v);
		while ((v ? periph_clk_div8 : irq) !== 1'h1 && n < 999) begin
			@(posedge aclk);
			n++;
			h += ext_osc_clk;
		end
		guard;
	endtask
	initial begin
		repeat (5) @(posedge aclk);
		aresetn <= 1'h1;
		rd(`CTRL_ADDR);
		chk(rdat, `CTRL_RESET);
		for (int m = 0; m < 8; m++) begin
			cm = {1'h1, m[2:0], 1'h1, 3'($random(seed))};
			wr(`CTRL_ADDR, cm[7:0]);
			cm = cm & 8'h77;
			chk(ext_osc_mode_sel, m);
			chk(drive_range_sel, cm & 7);
			chk(osc_enable, m > 1);
			chk(resonator_in_pin_claim, m > 5);
			chk(resonator_out_pin_claim, m > 1);
			rd(`CTRL_ADDR);
			chk(rdat, cm);
			rd(`OSC_STAT_ADDR);
			chk(rdat, (m > 1) * 5 + (m > 5) * 2);
		end
		$display("mode test done");
		wr(`IRQ_MASK_ADDR, 8'h1);
		rd(`IRQ_MASK_ADDR);
		chk(rdat, 32'h1);
		wr(`CTRL_ADDR, 8'h67);
		cm = 8'h67;
		stall <= 1'h0;
		n = 0;
		lvl(1'h0);
		rd(`CTRL_ADDR);
		chk(rdat, cm | 8'h80);
		wr(`IRQ_STAT_ADDR, 8'h1);
		chk(irq, 1'h0);
		stall <= 1'h1;
		repeat (80) @(posedge aclk);
		rd(`CTRL_ADDR);
		chk(rdat, cm);
		rd(`IRQ_STAT_ADDR);
		chk(rdat, 32'h2);
		chk(irq, 1'h0);
		$display("valid test done");
		stall <= 1'h0;
		for (int m = 2; m < 4; m++) begin
			wr(`CTRL_ADDR, {1'h0, m[2:0], 4'h0});
			n = 0;
			lvl(1'h1);
			while (periph_clk_div8 && n < 999) begin
				@(posedge aclk);
				n++;
			end
			lvl(1'h1);
			p = n;
			h = 0;
			while (periph_clk_div8 && n < 999) begin
				@(posedge aclk);
				n++;
				h += ext_osc_clk;
			end
			lvl(1'h1);
			chk(n - p, 48 * (m - 1));
			chk(h, 24 * (m - 1));
		end
		wr(`CTRL_ADDR, 8'h10);
		rd(`CTRL_ADDR);
		chk(rdat, 32'h10);
		n = 0;
		repeat (99) begin
			@(posedge aclk);
			n = n + periph_clk_div8 + ext_osc_clk;
		end
		chk(n, 0);
		rd(`OSC_STAT_ADDR);
		chk(rdat, 32'h0);
		wr(12'h0, 8'h1);
		chk(brsp, `RESP_SLVERR);
		rd(12'hffc);
		chk(rrsp, `RESP_SLVERR);
		$display("div and map test done");
		stop_test;
	end
endmodule // external_oscillator_control_bench

// ### bench/osc_source.sv
module osc_source (
	input wire aclk,
	input wire run,
	output logic osc_in
);
	timeunit 1ns;
	timeprecision 1ps;
	int k = 0;
	initial osc_in = 1'h0;
	// half period of three system clocks keeps it slower than the system clock
	always @(posedge aclk) begin
		k = (k + 1) % 3;
		if (!run)
			osc_in <= 1'h0;
		else if (k == 0)
			osc_in <= !osc_in;
	end
endmodule // osc_source

// ### logic/ext_osc_ctrl.v
// Notes on behaviour
// - modes 00x: oscillator off, no clock
// - 010 cmos direct, 011 cmos halved
// - 100 rc mode, 101 capacitor mode
// - 110 crystal, 111 crystal halved
// - read-only valid flag in bit seven
// - valid flag meaningful only in crystal modes
// - bit three reads zero, writes ignored
// - writable three-bit drive range to analog
// - crystal mode claims both resonator pins
// - rc, cap, cmos claim only output pin
// - selected clock (ext_osc_clk) divided by eight for peripherals
// - divided clock synchronized to system clock
// - hardware sets valid once oscillator settles in a crystal mode
`include "ext_osc_defs.vh"

module ext_osc_ctrl #(
	parameter [15:0] GAP_CYCLES = `GAP_CYCLES,
	parameter [15:0] SETTLE_EDGES = `SETTLE_EDGES
) (
	input wire aclk,
	input wire aresetn,
	input wire [11:0] s_axi_awaddr,
	input wire [2:0] s_axi_awprot,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [11:0] s_axi_araddr,
	input wire [2:0] s_axi_arprot,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	input wire osc_in,
	output reg osc_enable,
	output reg [2:0] ext_osc_mode_sel,
	output reg [2:0] drive_range_sel,
	output reg resonator_in_pin_claim,
	output reg resonator_out_pin_claim,
	output reg ext_osc_clk,
	output reg periph_clk_div8,
	output reg irq
);
	wire osc_level;
	wire osc_rise;
	reg aw_held;
	reg [11:0] awaddr_held;
	reg w_held;
	reg [31:0] wdata_held;
	reg [3:0] wstrb_held;
	reg crystal_valid_flag;
	reg valid_d;
	reg [15:0] edge_cnt;
	reg [15:0] gap_cnt;
	reg div2_reg;
	reg [1:0] div8_cnt;
	reg [1:0] irq_stat;
	reg [1:0] irq_mask;
	reg [1:0] irq_stat_next;
	reg [1:0] irq_mask_next;
	reg [2:0] mode_next;
	reg [2:0] range_next;
	reg [31:0] rdata_next;
	reg rd_mapped;
	reg wr_mapped;
	reg [1:0] stat_clr;
	reg [1:0] events;
	reg sel_edge;
	wire do_write;
	wire mode_off;
	wire mode_xtal;
	wire mode_div2;
	wire [7:0] ctrl_view;
	wire [7:0] stat_view;
	wire [7:0] ctrl_rst = `CTRL_RESET;

	osc_edge_sync osc_edge_sync_inst (
		.aclk(aclk),
		.aresetn(aresetn),
		.async_in(osc_in),
		.level(osc_level),
		.rise(osc_rise)
	);

	assign do_write = aw_held & w_held & ~s_axi_bvalid;
	assign mode_off = (ext_osc_mode_sel[2:1] == 2'b00);
	assign mode_xtal = (ext_osc_mode_sel[2:1] == 2'b11);
	assign mode_div2 = (ext_osc_mode_sel == `MODE_CMOS_DIV2) ||
		(ext_osc_mode_sel == `MODE_XTAL_DIV2);

	// valid shown only while a crystal mode is selected, bit three reads zero
	assign ctrl_view = {crystal_valid_flag & mode_xtal, ext_osc_mode_sel, 1'b0,
		drive_range_sel};
	assign stat_view = {3'h0, periph_clk_div8, ext_osc_clk, resonator_out_pin_claim,
		resonator_in_pin_claim, osc_enable};

	// register write decode
	always @* begin
		mode_next = ext_osc_mode_sel;
		range_next = drive_range_sel;
		irq_mask_next = irq_mask;
		stat_clr = 2'h0;
		wr_mapped = 1'b0;
		case ({awaddr_held[11:2], 2'b00})
			`CTRL_ADDR: begin
				wr_mapped = 1'b1;
				if (do_write && wstrb_held[0]) begin
					mode_next = wdata_held[`MODE_HI:`MODE_LO];
					range_next = wdata_held[`RANGE_HI:`RANGE_LO];
				end
			end
			`IRQ_STAT_ADDR: begin
				wr_mapped = 1'b1;
				if (do_write && wstrb_held[0])
					stat_clr = wdata_held[1:0];
			end
			`IRQ_MASK_ADDR: begin
				wr_mapped = 1'b1;
				if (do_write && wstrb_held[0])
					irq_mask_next = wdata_held[1:0];
			end
			`OSC_STAT_ADDR: begin
				wr_mapped = 1'b1;
			end
			default: begin
				wr_mapped = 1'b0;
			end
		endcase
	end

	// register read decode
	always @* begin
		rdata_next = 32'h0;
		rd_mapped = 1'b1;
		case ({s_axi_araddr[11:2], 2'b00})
			`CTRL_ADDR: begin
				rdata_next = {24'h0, ctrl_view};
			end
			`IRQ_STAT_ADDR: begin
				rdata_next = {30'h0, irq_stat};
			end
			`IRQ_MASK_ADDR: begin
				rdata_next = {30'h0, irq_mask};
			end
			`OSC_STAT_ADDR: begin
				rdata_next = {24'h0, stat_view};
			end
			default: begin
				rd_mapped = 1'b0;
			end
		endcase
	end

	// events and sticky status, a new event wins over a clear
	always @* begin
		events = 2'h0;
		events[`EV_VALID_SET] = crystal_valid_flag & ~valid_d;
		events[`EV_VALID_LOST] = ~crystal_valid_flag & valid_d;
		irq_stat_next = (irq_stat & ~stat_clr) | events;
		sel_edge = osc_rise & (~mode_div2 | ~div2_reg);
	end

	// axi4-lite handshakes
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `RESP_OKAY;
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= `RESP_OKAY;
			aw_held <= 1'b0;
			awaddr_held <= 12'h0;
			w_held <= 1'b0;
			wdata_held <= 32'h0;
			wstrb_held <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				awaddr_held <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				wdata_held <= s_axi_wdata;
				wstrb_held <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (do_write) begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_mapped ? `RESP_OKAY : `RESP_SLVERR;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rdata_next;
				s_axi_rresp <= rd_mapped ? `RESP_OKAY : `RESP_SLVERR;
			end
			if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end

	// control registers, pin claims and interrupt
	always @(posedge aclk) begin
		if (!aresetn) begin
			ext_osc_mode_sel <= ctrl_rst[`MODE_HI:`MODE_LO];
			drive_range_sel <= ctrl_rst[`RANGE_HI:`RANGE_LO];
			osc_enable <= 1'b0;
			resonator_in_pin_claim <= 1'b0;
			resonator_out_pin_claim <= 1'b0;
			irq_stat <= `IRQ_STAT_RESET;
			irq_mask <= `IRQ_MASK_RESET;
			irq <= 1'b0;
		end else begin
			ext_osc_mode_sel <= mode_next;
			drive_range_sel <= range_next;
			osc_enable <= (mode_next[2:1] != 2'b00);
			resonator_in_pin_claim <= (mode_next[2:1] == 2'b11);
			resonator_out_pin_claim <= (mode_next[2:1] != 2'b00);
			irq_stat <= irq_stat_next;
			irq_mask <= irq_mask_next;
			irq <= |(irq_stat_next & irq_mask_next);
		end
	end

	// crystal settle detector
	always @(posedge aclk) begin
		if (!aresetn) begin
			crystal_valid_flag <= 1'b0;
			valid_d <= 1'b0;
			edge_cnt <= 16'h0;
			gap_cnt <= 16'h0;
		end else begin
			valid_d <= crystal_valid_flag;
			if (!mode_xtal) begin
				crystal_valid_flag <= 1'b0;
				edge_cnt <= 16'h0;
				gap_cnt <= 16'h0;
			end else if (osc_rise) begin
				gap_cnt <= 16'h0;
				if (edge_cnt != SETTLE_EDGES)
					edge_cnt <= edge_cnt + 16'h1;
				else
					crystal_valid_flag <= 1'b1;
			end else if (gap_cnt == GAP_CYCLES - 16'h1) begin
				crystal_valid_flag <= 1'b0;
				edge_cnt <= 16'h0;
				gap_cnt <= 16'h0;
			end else begin
				gap_cnt <= gap_cnt + 16'h1;
			end
		end
	end

	// oscillator dividers, driven from synchronized edges only
	always @(posedge aclk) begin
		if (!aresetn) begin
			div2_reg <= 1'b0;
			div8_cnt <= 2'h0;
			ext_osc_clk <= 1'b0;
			periph_clk_div8 <= 1'b0;
		end else if (mode_off) begin
			div2_reg <= 1'b0;
			div8_cnt <= 2'h0;
			ext_osc_clk <= 1'b0;
			periph_clk_div8 <= 1'b0;
		end else begin
			if (osc_rise)
				div2_reg <= ~div2_reg;
			ext_osc_clk <= mode_div2 ? div2_reg : osc_level;
			if (sel_edge) begin
				div8_cnt <= div8_cnt + 2'h1;
				if (div8_cnt == 2'h3)
					periph_clk_div8 <= ~periph_clk_div8;
			end
		end
	end
endmodule // ext_osc_ctrl

// ### logic/ext_osc_defs.vh
`ifndef EXT_OSC_DEFS_VH
`define EXT_OSC_DEFS_VH

// register indices as printed, byte address is four times the index
`define CTRL_IDX 12'h0b1
`define IRQ_STAT_IDX 12'h0b4
`define IRQ_MASK_IDX 12'h0b5
`define OSC_STAT_IDX 12'h0b6
`define CTRL_ADDR 12'h2c4
`define IRQ_STAT_ADDR 12'h2d0
`define IRQ_MASK_ADDR 12'h2d4
`define OSC_STAT_ADDR 12'h2d8

// control register fields
`define VALID_BIT 7
`define MODE_HI 6
`define MODE_LO 4
`define RSVD_BIT 3
`define RANGE_HI 2
`define RANGE_LO 0
`define CTRL_RESET 8'h00

// mode codes
`define MODE_OFF0 3'h0
`define MODE_OFF1 3'h1
`define MODE_CMOS 3'h2
`define MODE_CMOS_DIV2 3'h3
`define MODE_RC 3'h4
`define MODE_CAP 3'h5
`define MODE_XTAL 3'h6
`define MODE_XTAL_DIV2 3'h7

// interrupt status bits
`define EV_VALID_SET 0
`define EV_VALID_LOST 1
`define IRQ_STAT_RESET 2'h0
`define IRQ_MASK_RESET 2'h0

// axi responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

// timing
// 8000 system clocks, about 40 us at 200 mhz
`define GAP_CYCLES 16'h1f40
`define SETTLE_EDGES 16'h0400

`endif

// ### logic/osc_edge_sync.v
module osc_edge_sync (
	input wire aclk,
	input wire aresetn,
	input wire async_in,
	output wire level,
	output wire rise
);
	reg meta_reg;
	reg sync_reg;
	reg prev_reg;

	always @(posedge aclk) begin
		if (!aresetn) begin
			meta_reg <= 1'b0;
			sync_reg <= 1'b0;
			prev_reg <= 1'b0;
		end else begin
			meta_reg <= async_in;
			sync_reg <= meta_reg;
			prev_reg <= sync_reg;
		end
	end

	assign level = sync_reg;
	assign rise = sync_reg & ~prev_reg;
endmodule // osc_edge_sync
